// *** src/ali_pkg.sv ***
// package: constants and carriers for the async line interface core
package ali_pkg;
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned FIFO_W     = 8;
  localparam int unsigned FIFO_D     = 8;
  // register index taken from address bits 2:1
  localparam logic [1:0] REG_RECEIVER_CONTROL_STATUS = 2'h0;
  localparam logic [1:0] REG_RECEIVE_BUFFER = 2'h1;
  localparam logic [1:0] REG_TRANSMITTER_CONTROL_STATUS = 2'h2;
  localparam logic [1:0] REG_TRANSMIT_BUFFER = 2'h3;
  // receiver control/status fields
  localparam int RC_READER = 0;
  localparam int RC_DTR    = 1;
  localparam int RC_RTS    = 2;
  localparam int RC_SECTX  = 3;
  localparam int RC_FBUSY  = 4;
  localparam int RC_DSIE   = 5;
  localparam int RC_IE     = 6;
  localparam int RC_DONE   = 7;
  localparam int RC_SECRX  = 10;
  localparam int RC_ACT    = 11;
  localparam int RC_CARR   = 12;
  localparam int RC_CTS    = 13;
  localparam int RC_RING   = 14;
  localparam int RC_DSCHG  = 15;
  localparam int RC_RATE   = 12;
  // transmitter control/status fields
  localparam int XC_BREAK = 0;
  localparam int XC_MAINT = 2;
  localparam int XC_IE    = 6;
  localparam int XC_READY = 7;
  // receive buffer error fields
  localparam int RB_PERR = 12;
  localparam int RB_FERR = 13;
  localparam int RB_OVR  = 14;
  localparam int RB_ERR  = 15;
  // framing error responses
  localparam logic [1:0] FE_HALT   = 2'h1;
  localparam logic [1:0] FE_REBOOT = 2'h2;
  localparam logic [3:0] SUB_MID   = 4'h7;
  localparam logic [3:0] SUB_END   = 4'hF;
  localparam logic [2:0] BITS_BASE = 3'h4;
  localparam logic [15:0] VEC_TX_OFS = 16'h0004;

  typedef struct packed {
    logic [12:3] addr_sel;    // address straps
    logic [8:3]  vec_sel;     // vector straps
    logic [3:0]  rx_rate;     // receive rate straps
    logic [3:0]  tx_rate;     // transmit rate straps
    logic        split;       // split speed
    logic        prog_baud;   // software rate enable
    logic        ext_tx_clk;  // use external 16x transmit clock
    logic        ext_rx_clk;  // use external 16x receive clock
    logic        break_rx_en;
    logic        break_tx_en;
    logic        parity_en;
    logic        parity_odd;
    logic [1:0]  data_bits;   // 5 + code data bits
    logic        two_stop;
    logic [1:0]  fe_action;   // ignore, halt, reboot
    logic        data_leads_only;
  } ali_cfg_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        io_page_select;
    logic        rd;
    logic        wr;
    logic        byte_op;
  } ali_bus_req_s;

  typedef struct packed {
    logic ring;
    logic carrier;
    logic cts;
    logic sec_rx;
  } ali_modem_in_s;

  typedef struct packed {
    logic dtr;
    logic rts;
    logic force_busy;
    logic sec_tx;
  } ali_modem_out_s;
endpackage : ali_pkg

// *** src/ali_core.sv ***
// file: async line interface core and its transmit fifo
`timescale 1ns/1ps

// ----------------------------------------
// fifo with valid/ready on both sides
// ----------------------------------------
module ali_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0]   cnt_q;
  logic          push, pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + AW'(1);
      if (pop)  rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ali_fifo

// ----------------------------------------
// core
// ----------------------------------------
// How it works
// - both buffers move one byte-wide character at a time.
// - reading the receive buffer returns the character with its error flags.
// - each direction has a shift register plus a holding register.
// - transmit buffer takes a parallel byte and shifts it out bit by bit.
// - a start bit from the line sets the receiver active bit; loading the character, which sets the done flag, clears it.
// - interrupts request only when enabled and a condition needs service.
// - on acknowledge the vector is driven onto the bus data.
// - separate receive and transmit vectors, chosen by the vector select strobe.
// - acknowledge passes receiver first, then transmitter, else downstream.
// - a fully received character raises the receiver condition.
// - an empty transmit holding register raises the transmitter condition.
// - modem handshake changes also raise the receiver interrupt.
// - common speed: one rate from rate straps or software upper four bits.
// - split speed: transmit rate from its own straps.
// - external receive and transmit clocks may replace the internal ones.
// - break is continuous spacing; receive and send each strap-enabled.
// - break missing stop bit is a framing error.
// - framing error: ignore, halt request, or drop supply ok, by strap.
// - maintenance loops transmit output to receiver, still driving the line.
// - four modem inputs and outputs through status registers; changes interrupt.
// - data-leads-only ignores inputs and holds request, busy, ready true.
// - software enable drives the reader run output.
// - respond only with page select and address bits 3-12 matching straps.
// - low three address bits select register and byte.
// - halt on framing error suppressed while maintenance is set.
// - parity inserted and checked, even or odd, when strapped on.
module ali_core (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire ali_pkg::ali_cfg_s     cfg,
  input  wire ali_pkg::ali_bus_req_s bus,
  output logic [15:0]                bus_rdata_q,
  output logic                       bus_reply_q,
  input  wire logic                  acknowledge_chain_in_n,
  output logic                       acknowledge_chain_out_n_q,
  output logic                       interrupt_request_line_n_q,
  output logic                       vector_select_strobe_q,
  output logic                       halt_request_line_n_q,
  output logic                       supply_ok_line_q,
  input  wire logic                  rx_line,
  output logic                       tx_line_q,
  input  wire logic                  ext_rx_clk,
  input  wire logic                  ext_tx_clk,
  input  wire ali_pkg::ali_modem_in_s  modem_in,
  output ali_pkg::ali_modem_out_s      modem_out_q,
  output logic                       reader_run_q
);
  import ali_pkg::*;

  // 16x divisor for a rate code at the system clock
  function automatic logic [15:0] rate_div(input logic [3:0] code);
    int unsigned baud;
    case (code)
      4'h0: baud = 50;     4'h1: baud = 75;    4'h2: baud = 110;   4'h3: baud = 200;
      4'h4: baud = 150;    4'h5: baud = 300;   4'h6: baud = 600;   4'h7: baud = 1200;
      4'h8: baud = 1800;   4'h9: baud = 2000;  4'hA: baud = 2400;  4'hB: baud = 3600;
      4'hC: baud = 4800;   4'hD: baud = 7200;  4'hE: baud = 9600;  default: baud = 19200;
    endcase
    return 16'(CLK_HZ / (OVERSAMPLE * baud) - 1);
  endfunction : rate_div

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_PAR  = 3'b011, RX_STOP  = 3'b100, RX_BRK  = 3'b101
  } ali_rx_e;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_PAR  = 3'b011, TX_STOP  = 3'b100
  } ali_tx_e;

  // ----------------------------------------
  // registers and decode
  // ----------------------------------------
  logic [15:0] receiver_control_status_q, transmitter_control_status_q, receive_buffer_q;
  logic [3:0]  prog_rate_q;
  logic        done_q, ready_q, act_q, dschg_q;
  logic        match, sel_rd, sel_wr, wr_lo, wr_hi;
  logic [1:0]  reg_idx;
  logic        maint;
  ali_modem_in_s mi, mi_q;

  assign match   = bus.io_page_select && (bus.addr[12:3] == cfg.addr_sel);
  assign reg_idx = bus.addr[2:1];
  assign sel_rd  = match && bus.rd;
  assign sel_wr  = match && bus.wr;
  assign wr_lo   = sel_wr && (!bus.byte_op || !bus.addr[0]);
  assign wr_hi   = sel_wr && (!bus.byte_op || bus.addr[0]);
  assign maint   = transmitter_control_status_q[XC_MAINT];
  assign mi      = cfg.data_leads_only ? '0 : modem_in;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      receiver_control_status_q      <= '0;
      transmitter_control_status_q      <= '0;
      prog_rate_q <= '0;
    end else begin
      if (wr_lo && reg_idx == REG_RECEIVER_CONTROL_STATUS) receiver_control_status_q[7:0] <= bus.wdata[7:0];
      if (wr_hi && reg_idx == REG_RECEIVER_CONTROL_STATUS) prog_rate_q <= bus.wdata[15:12];
      if (wr_lo && reg_idx == REG_TRANSMITTER_CONTROL_STATUS) transmitter_control_status_q[7:0] <= bus.wdata[7:0];
    end
  end

  // ----------------------------------------
  // baud rate ticks
  // ----------------------------------------
  logic [3:0]  rx_code, tx_code;
  logic [15:0] rx_div_q, tx_div_q;
  logic        rx_tick, tx_tick, ext_rx_q, ext_tx_q;

  always_comb begin
    rx_code = cfg.prog_baud ? prog_rate_q : cfg.rx_rate;
    if (cfg.split && maint) rx_code = cfg.tx_rate;
    tx_code = cfg.split ? cfg.tx_rate : rx_code;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_div_q <= '0;
      tx_div_q <= '0;
      // track the pins during reset so no false tick follows release
      ext_rx_q <= ext_rx_clk;
      ext_tx_q <= ext_tx_clk;
    end else begin
      ext_rx_q <= ext_rx_clk;
      ext_tx_q <= ext_tx_clk;
      rx_div_q <= (rx_div_q >= rate_div(rx_code)) ? '0 : rx_div_q + 16'h0001;
      tx_div_q <= (tx_div_q >= rate_div(tx_code)) ? '0 : tx_div_q + 16'h0001;
    end
  end

  assign rx_tick = cfg.ext_rx_clk ? (ext_rx_clk && !ext_rx_q)
                                  : (rx_div_q >= rate_div(rx_code));
  assign tx_tick = cfg.ext_tx_clk ? (ext_tx_clk && !ext_tx_q)
                                  : (tx_div_q >= rate_div(tx_code));

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  ali_rx_e     rx_st_q;
  logic [3:0]  rx_sub_q;
  logic [2:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  logic        rx_perr_q, rx_in, rx_mid, rx_end, rx_last, rx_ferr, rx_load;
  logic        receive_buffer_rd;

  assign rx_in   = maint ? tx_line_q : rx_line;
  assign rx_mid  = rx_tick && (rx_sub_q == SUB_MID);
  assign rx_end  = rx_tick && (rx_sub_q == SUB_END);
  assign rx_last = (rx_bit_q == BITS_BASE + 3'(cfg.data_bits));
  assign rx_load = rx_end && (rx_st_q == RX_STOP);
  assign rx_ferr = rx_load && !rx_in;
  assign receive_buffer_rd = sel_rd && reg_idx == REG_RECEIVE_BUFFER && !bus.addr[0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_st_q   <= RX_IDLE;
      rx_sub_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_perr_q <= 1'b0;
    end else if (rx_tick) begin
      rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_st_q)
        RX_IDLE: begin
          rx_sub_q <= '0;
          if (!rx_in) rx_st_q <= RX_START;
        end
        RX_START: if (rx_mid) begin
          rx_sub_q  <= '0;
          rx_bit_q  <= '0;
          rx_sh_q   <= '0;
          rx_perr_q <= 1'b0;
          rx_st_q   <= rx_in ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_end) begin
          rx_sh_q[rx_bit_q] <= rx_in;
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_last) rx_st_q <= cfg.parity_en ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rx_end) begin
          rx_perr_q <= (^rx_sh_q ^ rx_in) != cfg.parity_odd;
          rx_st_q   <= RX_STOP;
        end
        RX_STOP: if (rx_end) rx_st_q <= rx_in ? RX_IDLE : RX_BRK;
        RX_BRK: if (rx_in) rx_st_q <= RX_IDLE;
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // holding register, done and active
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      receive_buffer_q <= '0;
      done_q <= 1'b0;
      act_q  <= 1'b0;
    end else begin
      if (rx_load) begin
        receive_buffer_q          <= '0;
        receive_buffer_q[7:0]     <= rx_sh_q;
        receive_buffer_q[RB_PERR] <= rx_perr_q;
        receive_buffer_q[RB_FERR] <= rx_ferr;
        receive_buffer_q[RB_OVR]  <= done_q && !receive_buffer_rd;
        receive_buffer_q[RB_ERR]  <= rx_perr_q || rx_ferr || (done_q && !receive_buffer_rd);
      end
      if (rx_load) done_q <= 1'b1;
      else if (receive_buffer_rd) done_q <= 1'b0;
      if (rx_st_q == RX_START && rx_mid && !rx_in) act_q <= 1'b1;
      else if (rx_load) act_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // framing error response
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      halt_request_line_n_q <= 1'b1;
      supply_ok_line_q      <= 1'b1;
    end else if (rx_ferr && cfg.break_rx_en) begin
      halt_request_line_n_q <= !(cfg.fe_action == FE_HALT && !maint);
      supply_ok_line_q      <= !(cfg.fe_action == FE_REBOOT);
    end else if (rx_in && rx_st_q != RX_BRK) begin
      halt_request_line_n_q <= 1'b1;
      supply_ok_line_q      <= 1'b1;
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  ali_tx_e    tx_st_q;
  logic [7:0] hold_q, tx_sh_q, fifo_data;
  logic [3:0] tx_sub_q;
  logic [2:0] tx_bit_q;
  logic       tx_par_q, tx_stop2_q, hold_full_q, fifo_in_ready, fifo_valid;
  logic       tx_pop, tx_bit_end, transmit_buffer_wr;

  assign transmit_buffer_wr    = wr_lo && reg_idx == REG_TRANSMIT_BUFFER;
  assign tx_bit_end = tx_tick && (tx_sub_q == SUB_END);
  assign tx_pop     = (tx_st_q == TX_IDLE) && tx_tick;

  // holding register feeds the fifo; a full fifo stalls the holding register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hold_q      <= '0;
      hold_full_q <= 1'b0;
    end else begin
      if (transmit_buffer_wr && !hold_full_q) begin
        hold_q      <= bus.wdata[7:0];
        hold_full_q <= 1'b1;
      end else if (hold_full_q && fifo_in_ready) begin
        hold_full_q <= 1'b0;
      end
    end
  end
  assign ready_q = !hold_full_q;

  ali_fifo #(.W(FIFO_W), .D(FIFO_D)) u_tx_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_data   (hold_q),
    .in_valid  (hold_full_q),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (tx_pop)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_st_q    <= TX_IDLE;
      tx_sub_q   <= '0;
      tx_bit_q   <= '0;
      tx_sh_q    <= '0;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
    end else if (tx_tick) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      case (tx_st_q)
        TX_IDLE: begin
          tx_sub_q <= '0;
          if (fifo_valid) begin
            tx_sh_q  <= fifo_data;
            tx_par_q <= cfg.parity_odd;
            tx_st_q  <= TX_START;
          end
        end
        TX_START: if (tx_bit_end) begin
          tx_bit_q <= '0;
          tx_st_q  <= TX_DATA;
        end
        TX_DATA: if (tx_bit_end) begin
          tx_par_q <= tx_par_q ^ tx_sh_q[0];
          tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
          tx_bit_q <= tx_bit_q + 3'h1;
          if (tx_bit_q == BITS_BASE + 3'(cfg.data_bits)) begin
            tx_st_q    <= cfg.parity_en ? TX_PAR : TX_STOP;
            tx_stop2_q <= cfg.two_stop;
          end
        end
        TX_PAR: if (tx_bit_end) tx_st_q <= TX_STOP;
        TX_STOP: if (tx_bit_end) begin
          tx_stop2_q <= 1'b0;
          if (!tx_stop2_q) tx_st_q <= TX_IDLE;
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_line_q <= 1'b1;
    end else if (transmitter_control_status_q[XC_BREAK] && cfg.break_tx_en) begin
      tx_line_q <= 1'b0;
    end else begin
      case (tx_st_q)
        TX_START: tx_line_q <= 1'b0;
        TX_DATA:  tx_line_q <= tx_sh_q[0];
        TX_PAR:   tx_line_q <= tx_par_q;
        default:  tx_line_q <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // modem lines and reader run
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mi_q         <= mi;
      dschg_q      <= 1'b0;
      modem_out_q  <= '0;
      reader_run_q <= 1'b0;
    end else begin
      mi_q <= mi;
      if (mi != mi_q) dschg_q <= 1'b1;
      else if (sel_rd && reg_idx == REG_RECEIVER_CONTROL_STATUS) dschg_q <= 1'b0;
      modem_out_q.dtr        <= receiver_control_status_q[RC_DTR]   || cfg.data_leads_only;
      modem_out_q.rts        <= receiver_control_status_q[RC_RTS]   || cfg.data_leads_only;
      modem_out_q.force_busy <= receiver_control_status_q[RC_FBUSY] || cfg.data_leads_only;
      modem_out_q.sec_tx     <= receiver_control_status_q[RC_SECTX];
      reader_run_q <= receiver_control_status_q[RC_READER] && !act_q;
    end
  end

  // ----------------------------------------
  // interrupts and acknowledge chain
  // ----------------------------------------
  logic rx_cond, tx_cond, rx_cond_q, tx_cond_q, rx_req_q, tx_req_q;
  logic ack, ack_q, claim_rx, claim_tx;

  assign rx_cond  = receiver_control_status_q[RC_IE] && (done_q
                    || (receiver_control_status_q[RC_DSIE] && dschg_q));
  assign tx_cond  = transmitter_control_status_q[XC_IE] && ready_q;
  assign ack      = !acknowledge_chain_in_n;
  assign claim_rx = ack && !ack_q && rx_req_q;
  assign claim_tx = ack && !ack_q && !rx_req_q && tx_req_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_cond_q <= 1'b0;
      tx_cond_q <= 1'b0;
      rx_req_q  <= 1'b0;
      tx_req_q  <= 1'b0;
      ack_q     <= 1'b0;
      interrupt_request_line_n_q <= 1'b1;
      acknowledge_chain_out_n_q  <= 1'b1;
    end else begin
      rx_cond_q <= rx_cond;
      tx_cond_q <= tx_cond;
      ack_q     <= ack;
      if (rx_cond && !rx_cond_q) rx_req_q <= 1'b1;
      else if (claim_rx || !rx_cond) rx_req_q <= 1'b0;
      if (tx_cond && !tx_cond_q) tx_req_q <= 1'b1;
      else if (claim_tx || !tx_cond) tx_req_q <= 1'b0;
      interrupt_request_line_n_q <= !(rx_req_q || tx_req_q);
      if (!ack) acknowledge_chain_out_n_q <= 1'b1;
      else if (!ack_q && !rx_req_q && !tx_req_q) acknowledge_chain_out_n_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // bus answer: register reads and vectors
  // ----------------------------------------
  logic [15:0] rd_word, vec_base;

  assign vec_base = {7'h00, cfg.vec_sel, 3'h0};

  always_comb begin
    case (reg_idx)
      REG_RECEIVER_CONTROL_STATUS: begin
        rd_word            = {8'h00, receiver_control_status_q[7:0]};
        rd_word[RC_DONE]   = done_q;
        rd_word[RC_ACT]    = act_q;
        rd_word[RC_SECRX]  = mi_q.sec_rx;
        rd_word[RC_CARR]   = mi_q.carrier;
        rd_word[RC_CTS]    = mi_q.cts;
        rd_word[RC_RING]   = mi_q.ring;
        rd_word[RC_DSCHG]  = dschg_q;
      end
      REG_RECEIVE_BUFFER: rd_word = receive_buffer_q;
      REG_TRANSMITTER_CONTROL_STATUS: begin
        rd_word           = {8'h00, transmitter_control_status_q[7:0]};
        rd_word[XC_READY] = ready_q;
      end
      default: rd_word = '0;
    endcase
    if (bus.byte_op && bus.addr[0]) rd_word = {8'h00, rd_word[15:8]};
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_rdata_q            <= '0;
      bus_reply_q            <= 1'b0;
      vector_select_strobe_q <= 1'b0;
    end else begin
      bus_reply_q <= sel_rd || sel_wr || claim_rx || claim_tx;
      if (claim_rx) begin
        bus_rdata_q            <= vec_base;
        vector_select_strobe_q <= 1'b0;
      end else if (claim_tx) begin
        bus_rdata_q            <= vec_base + VEC_TX_OFS;
        vector_select_strobe_q <= 1'b1;
      end else if (sel_rd) begin
        bus_rdata_q <= rd_word;
      end
    end
  end
endmodule : ali_core

// *** dv/ali_term.sv ***
// serial terminal model on the far side of the line
`timescale 1ns/1ps
// ----------------------------------------
// terminal
// ----------------------------------------
module ali_term (
  input  wire logic clk_sys,
  input  wire logic tx_line_q,
  output logic      rx_line
);
  localparam int BIT = 256;
  initial rx_line = 1'b1;
  // start, eight data lsb first, one stop
  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BIT) @(posedge clk_sys);
    end
  endtask : send
  // samples each bit at its middle
  task recv(output logic [7:0] b, output logic s);
    while (tx_line_q) @(posedge clk_sys);
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_sys);
      b[i] = tx_line_q;
    end
    repeat (BIT) @(posedge clk_sys);
    s = tx_line_q;
  endtask : recv
endmodule : ali_term

// *** dv/ali_monitor.sv ***
// checker: port assertions for the line interface core
`timescale 1ns/1ps
// ----------------------------------------
// checker
// ----------------------------------------
module ali_monitor import ali_pkg::*; (
  input wire logic           clk_sys,
  input wire logic           reset,
  input wire ali_cfg_s       cfg,
  input wire ali_bus_req_s   bus,
  input wire logic [15:0]    bus_rdata_q,
  input wire logic           bus_reply_q,
  input wire logic           acknowledge_chain_in_n,
  input wire logic           acknowledge_chain_out_n_q,
  input wire logic           interrupt_request_line_n_q,
  input wire logic           vector_select_strobe_q,
  input wire logic           halt_request_line_n_q,
  input wire logic           supply_ok_line_q,
  input wire logic           tx_line_q,
  input wire ali_modem_out_s modem_out_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire m = (bus.rd | bus.wr) & bus.io_page_select & (bus.addr[12:3] == cfg.addr_sel);
  property p_reply; m |=> bus_reply_q; endproperty
  a_reply: assert property (p_reply) else $error("matched access not answered");
  property p_quiet; !m && acknowledge_chain_in_n |=> !bus_reply_q; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_idle; $fell(reset) |-> tx_line_q && interrupt_request_line_n_q; endproperty
  a_idle: assert property (p_idle) else $error("line not marking after reset");
  property p_vec;
    bus_reply_q && !$past(acknowledge_chain_in_n) && $past(acknowledge_chain_in_n, 2)
      && !vector_select_strobe_q |-> bus_rdata_q == {7'h00, cfg.vec_sel, 3'h0};
  endproperty
  a_vec: assert property (p_vec) else $error("wrong receive vector");
  property p_chain; acknowledge_chain_in_n |=> acknowledge_chain_out_n_q; endproperty
  a_chain: assert property (p_chain) else $error("chain out low without in");
  property p_sok; cfg.fe_action != FE_REBOOT |-> supply_ok_line_q; endproperty
  a_sok: assert property (p_sok) else $error("supply ok dropped");
  property p_halt; cfg.fe_action != FE_HALT |-> halt_request_line_n_q; endproperty
  a_halt: assert property (p_halt) else $error("halt not strapped");
  property p_dlo;
    cfg.data_leads_only |=> modem_out_q.dtr && modem_out_q.rts && modem_out_q.force_busy;
  endproperty
  a_dlo: assert property (p_dlo) else $error("outgoing controls not true");
  c_reply: cover property (bus_reply_q);
  c_irq: cover property (!interrupt_request_line_n_q);
  c_tx: cover property (!tx_line_q);
endmodule : ali_monitor
bind ali_core ali_monitor u_mon (
  .clk_sys(clk_sys), .reset(reset), .cfg(cfg), .bus(bus), .bus_rdata_q(bus_rdata_q),
  .bus_reply_q(bus_reply_q), .acknowledge_chain_in_n(acknowledge_chain_in_n),
  .acknowledge_chain_out_n_q(acknowledge_chain_out_n_q),
  .interrupt_request_line_n_q(interrupt_request_line_n_q),
  .vector_select_strobe_q(vector_select_strobe_q),
  .halt_request_line_n_q(halt_request_line_n_q), .supply_ok_line_q(supply_ok_line_q),
  .tx_line_q(tx_line_q), .modem_out_q(modem_out_q));

// *** dv/tb.sv ***
// testbench: bus accesses, serial traffic and interrupt claim
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module tb;
  import ali_pkg::*;
  localparam logic [9:0] ADR = 10'h3F2;
  logic         clk_sys = 1'b0, reset = 1'b1, ack_n = 1'b1, xck = 1'b0;
  logic         rxl, got, st, rp, ao, irq_n, vs, hn, sok, tx, rr;
  logic [15:0]  q, rd;
  logic [7:0]   b;
  int           n_fail = 0, checked = 0, cyc = 0;
  ali_cfg_s     cfg;
  ali_bus_req_s bus;
  ali_modem_out_s mo;
  ali_modem_in_s  mi = '0;
  always #50 clk_sys = ~clk_sys;
  // external 16x clock, one tick every 16 cycles
  always begin
    repeat (8) @(posedge clk_sys);
    xck <= ~xck;
  end
  ali_core u_dut (.clk_sys(clk_sys), .reset(reset), .cfg(cfg), .bus(bus),
    .bus_rdata_q(rd), .bus_reply_q(rp), .acknowledge_chain_in_n(ack_n),
    .acknowledge_chain_out_n_q(ao), .interrupt_request_line_n_q(irq_n),
    .vector_select_strobe_q(vs), .halt_request_line_n_q(hn), .supply_ok_line_q(sok),
    .rx_line(rxl), .tx_line_q(tx), .ext_rx_clk(xck), .ext_tx_clk(xck),
    .modem_in(mi), .modem_out_q(mo), .reader_run_q(rr));
  ali_term u_term (.clk_sys(clk_sys), .tx_line_q(tx), .rx_line(rxl));
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one access; the answer stands in the cycle after it is taken
  task acc(input logic w, input logic [1:0] i, input logic [15:0] d, input logic p);
    @(posedge clk_sys);
    bus <= '{{3'h0, ADR, i, 1'b0}, d, p, !w, w, 1'b0};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    bus.wr <= 1'b0;
    @(negedge clk_sys);
    got = rp;
    q = rd;
  endtask : acc
  task close_out;
    $display("counts: %0d checked, %0d failed", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    cfg = '0;
    cfg.addr_sel = ADR;
    cfg.vec_sel = 6'h0C;
    cfg.ext_tx_clk = 1'b1;
    cfg.ext_rx_clk = 1'b1;
    cfg.data_bits = 2'h3;
    cfg.data_leads_only = 1'b1;
    bus = '0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk("idle", 16'h0003, {14'h0, tx, irq_n});
    $display("test idle done");
    acc(1'b1, REG_TRANSMIT_BUFFER, 16'h00A5, 1'b1);
    u_term.recv(b, st);
    chk("tx frame", 16'h01A5, {7'h0, st, b});
    $display("test transmit done");
    acc(1'b1, REG_RECEIVER_CONTROL_STATUS, 16'h0040, 1'b1);
    u_term.send(8'h3C);
    repeat (40) if (irq_n) @(posedge clk_sys);
    chk("irq", 16'h0000, {15'h0, irq_n});
    @(posedge clk_sys);
    ack_n <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("vector", 16'hA060, {rp, vs, ao, rd[12:0]});
    @(posedge clk_sys);
    ack_n <= 1'b1;
    acc(1'b0, REG_RECEIVE_BUFFER, 16'h0000, 1'b1);
    chk("receive_buffer", 16'h003C, q);
    acc(1'b0, REG_RECEIVER_CONTROL_STATUS, 16'h0000, 1'b1);
    chk("done", 16'h0000, {15'h0, q[RC_DONE]});
    $display("test receive done");
    acc(1'b1, REG_TRANSMITTER_CONTROL_STATUS, 16'h0004, 1'b1);
    acc(1'b1, REG_TRANSMIT_BUFFER, 16'h005A, 1'b1);
    repeat (3000) if (irq_n) @(posedge clk_sys);
    acc(1'b0, REG_RECEIVE_BUFFER, 16'h0000, 1'b1);
    chk("loop", 16'h005A, q);
    $display("test loop done");
    acc(1'b1, REG_RECEIVER_CONTROL_STATUS, 16'h0041, 1'b1);
    @(posedge clk_sys);
    mi <= '1;
    @(negedge clk_sys);
    chk("reader", 16'h000F, {12'h0, rr, mo.dtr, mo.rts, mo.force_busy});
    acc(1'b0, REG_RECEIVER_CONTROL_STATUS, 16'h0000, 1'b1);
    chk("ignore in", 16'h0000, {10'h0, q[15:10]});
    @(posedge clk_sys);
    ack_n <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("pass on", 16'h0000, {14'h0, rp, ao});
    @(posedge clk_sys);
    ack_n <= 1'b1;
    $display("test modem done");
    acc(1'b0, REG_RECEIVER_CONTROL_STATUS, 16'h0000, 1'b0);
    chk("no page", 16'h0000, {15'h0, got});
    $display("test decode done");
    close_out;
  end
endmodule : tb
